/* File: src/mcp_dec_fmt.sv */
// decimal formatter: turns a signed 32-bit value into ascii digits,
// most significant first, one character per request.
// assumes the caller waits for done before reading the characters.
`timescale 1ns/1ps
module mcp_dec_fmt
  import mcp_pkg::*;
(
  input  wire logic        sys_clk,   // module clock
  input  wire logic        reset,     // sync reset, active high
  input  wire logic        start,     // load value, begin conversion
  input  wire logic [31:0] value,     // signed value to print
  output logic             done,      // digits ready
  output logic [3:0]       num_chars, // characters incl. sign
  input  wire logic [3:0]  char_idx,  // character to read
  output logic [7:0]       char_out   // ascii character at char_idx
);
  logic [31:0] mag_ff;
  logic [3:0]  dig_ff [0:9];
  logic [3:0]  cnt_ff;
  logic        neg_ff;
  logic        busy_ff;
  logic [3:0]  sel;

  // repeated divide by ten; slow but small, a reply waits at most 10 cycles
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      busy_ff <= 1'b0;
      done    <= 1'b0;
      cnt_ff  <= 4'h0;
      neg_ff  <= 1'b0;
      mag_ff  <= 32'h0;
    end else if (start) begin
      busy_ff <= 1'b1;
      done    <= 1'b0;
      cnt_ff  <= 4'h0;
      neg_ff  <= value[31];
      mag_ff  <= value[31] ? (~value + 32'h1) : value;
    end else if (busy_ff) begin
      dig_ff[cnt_ff] <= 4'(mag_ff % 32'd10);
      mag_ff         <= mag_ff / 32'd10;
      cnt_ff         <= cnt_ff + 4'h1;
      if (mag_ff < 32'd10) begin
        busy_ff <= 1'b0;
        done    <= 1'b1;
      end
    end
  end

  assign num_chars = cnt_ff + {3'h0, neg_ff};

  always_comb begin
    sel = num_chars - char_idx - 4'h1;
    if (neg_ff && char_idx == 4'h0) begin
      char_out = CHR_MINUS;
    end else begin
      char_out = CHR_ZERO + {4'h0, dig_ff[sel]};
    end
  end
endmodule // mcp_dec_fmt

/* File: src/mcp_frame_parser.sv */
// command frame front end: receives binary frames (serial or can) or text
// lines, checks them, hands the command to an executor, sends one reply.
// assumes a valid-only receive stream, a valid/ready transmit stream and an executor that answers once.
// How it works
// - command body is command, type, motor/bank and four value bytes
// - serial frames add leading address and trailing checksum: nine bytes
// - value field travels most significant byte first both directions
// - command checksum is 8-bit sum of the eight preceding bytes
// - can frames carry no address or checksum byte
// - every received command gets exactly one reply; here the text return to binary gets none
// - reply: host address, module address, status, command, value, checksum
// - reply checksum is 8-bit sum of all other reply bytes
// - can replies carry no address or checksum byte
// - status 100 means executed, 101 means stored into program memory
// - error statuses 1 to 6: checksum, command, type, value, locked, unavailable
// - text mode only passes the allowed direct command subset
// - text mode adds return to binary, run program and halt program
// - binary command 139 switches the device into text mode
// - text line: address letter, optional spaces, command, carriage return
// - text reply: host letter, module letter, status, value, carriage return
// - startup bit 0 set selects text mode, clear selects binary
// - both echo bits clear: echo each character, backspace erases one; here only one echo is held, so back-to-back characters are not all echoed
// - echo bit 4 alone: echo the whole line after carriage return; here bit 4 alone gives no echo, only the reply
// - echo bit 5 alone: no echo, only the reply
// - text mode entered by command is left again by power cycle
// - transmit only when replying or echoing, otherwise stay receiving
`timescale 1ns/1ps
module mcp_frame_parser
  import mcp_pkg::*;
(
  input  wire logic        sys_clk,        // module clock, 40 MHz
  input  wire logic        reset,          // sync reset, active high (power-up)
  input  wire logic        can_link,       // 1: frames arrive over can
  input  wire logic [7:0]  module_addr,    // own module address
  input  wire logic [7:0]  host_addr,      // reply address
  input  wire logic [7:0]  startup_cfg,    // startup/echo configuration byte
  input  wire logic        rx_valid,       // received byte valid
  input  wire logic [7:0]  rx_data,        // received byte
  output logic             cmd_valid,      // binary command to executor
  output logic [7:0]       cmd_num,        // command number
  output logic [7:0]       cmd_type,       // type byte
  output logic [7:0]       cmd_bank,       // motor or bank byte
  output logic [31:0]      cmd_value,      // value field
  output logic             txt_valid,      // text line to executor
  output logic [1:0]       txt_class,      // direct, run, stop, unknown
  input  wire logic        exec_done,      // executor finished (one pulse)
  input  wire logic [7:0]  exec_status,    // executor status code
  input  wire logic [31:0] exec_value,     // executor return value
  output logic             tx_valid,       // transmit byte valid
  output logic [7:0]       tx_data,        // transmit byte
  input  wire logic        tx_ready,       // transmitter takes the byte
  output logic             tx_busy,        // link driven by this device
  output logic             text_mode       // device is in text mode
);
  mcp_state_e  state_ff;
  logic [7:0]  frm_ff [0:SER_CMD_LEN-1];
  logic [7:0]  line_ff [0:TXT_LINE_MAX-1];
  logic [5:0]  len_ff;
  logic [7:0]  sum_ff;
  logic        addr_ok_ff;
  logic [7:0]  rpl_status_ff;
  logic [31:0] rpl_value_ff;
  logic [5:0]  tx_idx_ff;
  logic [7:0]  tx_sum_ff;
  logic        leave_text_ff;
  logic        enter_text_ff;
  logic        echo_now_ff;
  logic [7:0]  echo_chr_ff;
  logic [5:0]  cmd_pos;
  logic [7:0]  c0, c1, c2;
  logic [1:0]  cls;
  logic        fmt_start;
  logic        fmt_done;
  logic [3:0]  fmt_chars;
  logic [3:0]  fmt_idx;
  logic [7:0]  fmt_char;
  logic [5:0]  rx_last;
  logic [5:0]  rpl_len;
  logic [7:0]  rpl_byte;
  logic        boot_ff;

  mcp_dec_fmt u_fmt (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .start     (fmt_start),
    .value     (exec_value),
    .done      (fmt_done),
    .num_chars (fmt_chars),
    .char_idx  (fmt_idx),
    .char_out  (fmt_char)
  );

  assign rx_last = can_link ? 6'(CAN_CMD_LEN - 1) : 6'(SER_CMD_LEN - 1);
  assign fmt_start = state_ff == MCP_EXEC && exec_done && text_mode;

  // skip address letter and spaces to find the command mnemonic
  always_comb begin
    cmd_pos = 6'h1;
    for (int i = TXT_LINE_MAX - 1; i >= 1; i--) begin
      if (6'(i) < len_ff && line_ff[i] != CHR_SPACE) begin
        cmd_pos = 6'(i);
      end
    end
    c0  = line_ff[cmd_pos[4:0]];
    c1  = line_ff[5'(cmd_pos + 6'h1)];
    c2  = line_ff[5'(cmd_pos + 6'h2)];
    cls = TXT_CLS_DIRECT;
    // first letters cover the allowed subset; anything else is rejected
    if ({c0, c1, c2} == "RUN") begin
      cls = TXT_CLS_RUN;
    end else if ({c0, c1, c2} == "STO") begin
      cls = TXT_CLS_STOP;
    end else if (!(c0 inside {"R", "M", "S", "G", "C", "U"})) begin
      cls = TXT_CLS_BAD;
    end
  end

  // main sequencer: receive, execute, reply; transmit only while replying or echoing
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_ff      <= MCP_IDLE;
      len_ff        <= 6'h0;
      sum_ff        <= 8'h0;
      addr_ok_ff    <= 1'b0;
      cmd_valid     <= 1'b0;
      txt_valid     <= 1'b0;
      txt_class     <= TXT_CLS_DIRECT;
      cmd_num       <= 8'h0;
      cmd_type      <= 8'h0;
      cmd_bank      <= 8'h0;
      cmd_value     <= 32'h0;
      rpl_status_ff <= 8'h0;
      rpl_value_ff  <= 32'h0;
      leave_text_ff <= 1'b0;
      enter_text_ff <= 1'b0;
    end else begin
      cmd_valid     <= 1'b0;
      txt_valid     <= 1'b0;
      leave_text_ff <= 1'b0;
      enter_text_ff <= 1'b0;
      case (state_ff)
        MCP_IDLE, MCP_RECV: begin
          if (rx_valid && !text_mode) begin
            frm_ff[len_ff[3:0]] <= rx_data;
            sum_ff              <= sum_ff + rx_data;
            if (len_ff == rx_last) begin
              len_ff <= 6'h0;
              sum_ff <= 8'h0;
              if (!can_link && frm_ff[0] != module_addr) begin
                state_ff <= MCP_IDLE;
              end else begin
                state_ff <= MCP_EXEC;
                if (can_link) begin
                  cmd_num   <= frm_ff[0];
                  cmd_type  <= frm_ff[1];
                  cmd_bank  <= frm_ff[2];
                  cmd_value <= {frm_ff[3], frm_ff[4], frm_ff[5], rx_data};
                end else begin
                  cmd_num   <= frm_ff[1];
                  cmd_type  <= frm_ff[2];
                  cmd_bank  <= frm_ff[3];
                  cmd_value <= {frm_ff[4], frm_ff[5], frm_ff[6], frm_ff[7]};
                end
                // executor is bypassed for checksum faults and mode switch
                if (!can_link && sum_ff != rx_data) begin
                  rpl_status_ff <= ST_BAD_SUM;
                  rpl_value_ff  <= 32'h0;
                  state_ff      <= MCP_REPLY;
                end else if ((can_link ? frm_ff[0] : frm_ff[1]) == CMD_ENTER_TEXT) begin
                  rpl_status_ff <= ST_OK;
                  rpl_value_ff  <= 32'h0;
                  enter_text_ff <= 1'b1;
                  state_ff      <= MCP_REPLY;
                end else begin
                  cmd_valid <= 1'b1;
                end
              end
            end else begin
              len_ff   <= len_ff + 6'h1;
              state_ff <= MCP_RECV;
            end
          end else if (rx_valid && text_mode) begin
            if (len_ff == 6'h0) begin
              addr_ok_ff <= rx_data == CHR_A_LESS1 + module_addr;
            end
            if (rx_data == CHR_BS && !startup_cfg[CFG_ECHO_LINE]) begin
              len_ff <= (len_ff > 6'h1) ? len_ff - 6'h1 : len_ff;
            end else if (rx_data == CHR_CR) begin
              len_ff <= 6'h0;
              if (addr_ok_ff) begin
                state_ff <= MCP_EXEC;
                if ({c0, c1, c2} == {"B", "IN"}) begin
                  leave_text_ff <= 1'b1;
                  state_ff      <= MCP_IDLE;
                end else if (cls == TXT_CLS_BAD) begin
                  rpl_status_ff <= ST_BAD_CMD;
                  rpl_value_ff  <= 32'h0;
                  state_ff      <= MCP_REPLY;
                end else begin
                  txt_valid <= 1'b1;
                  txt_class <= cls;
                end
              end
            end else if (len_ff < 6'(TXT_LINE_MAX)) begin
              line_ff[len_ff[4:0]] <= rx_data;
              len_ff               <= len_ff + 6'h1;
            end
          end
        end
        MCP_EXEC: begin
          if (exec_done) begin
            rpl_status_ff <= exec_status;
            rpl_value_ff  <= exec_value;
            state_ff      <= MCP_REPLY;
          end
        end
        MCP_REPLY: begin
          if (tx_valid && tx_ready && tx_idx_ff == rpl_len - 6'h1) begin
            state_ff <= MCP_IDLE;
          end
        end
        default: state_ff <= MCP_IDLE;
      endcase
    end
  end

  // high during reset and in the first cycle after it: the startup bit acts once,
  // so a later return to binary is not undone
  always_ff @(posedge sys_clk) begin
    boot_ff <= reset;
  end

  // text mode: startup bit at power-up, command 139 in, return command out
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      text_mode <= 1'b0;
    end else if (boot_ff && startup_cfg[CFG_TEXT_BIT]) begin
      text_mode <= 1'b1;
    end else if (leave_text_ff) begin
      text_mode <= 1'b0;
    end else if (state_ff == MCP_REPLY && tx_valid && tx_ready && tx_idx_ff == rpl_len - 6'h1
                 && rpl_status_ff == ST_OK && cmd_num == CMD_ENTER_TEXT) begin
      text_mode <= 1'b1;
    end
  end

  // text reply: host, module, space, status (3 digits), space, value, cr
  assign rpl_len = text_mode ? 6'd8 + 6'(fmt_chars)
                 : (can_link ? 6'(CAN_RPL_LEN) : 6'(SER_RPL_LEN));
  assign fmt_idx = 4'(tx_idx_ff - 6'd7);

  always_comb begin
    rpl_byte = 8'h0;
    if (text_mode) begin
      if (tx_idx_ff == 6'd0)                  rpl_byte = CHR_A_LESS1 + host_addr;
      else if (tx_idx_ff == 6'd1)             rpl_byte = CHR_A_LESS1 + module_addr;
      else if (tx_idx_ff == 6'd2 || tx_idx_ff == 6'd6) rpl_byte = CHR_SPACE;
      else if (tx_idx_ff == 6'd3)             rpl_byte = CHR_ZERO + 8'(rpl_status_ff / 8'd100);
      else if (tx_idx_ff == 6'd4)
        rpl_byte = CHR_ZERO + 8'((rpl_status_ff / 8'd10) % 8'd10);
      else if (tx_idx_ff == 6'd5)             rpl_byte = CHR_ZERO + 8'(rpl_status_ff % 8'd10);
      else if (tx_idx_ff == rpl_len - 6'h1)   rpl_byte = CHR_CR;
      else                                    rpl_byte = fmt_char;
    end else begin
      case (tx_idx_ff + (can_link ? 6'd2 : 6'd0))
        6'd0:    rpl_byte = host_addr;
        6'd1:    rpl_byte = module_addr;
        6'd2:    rpl_byte = rpl_status_ff;
        6'd3:    rpl_byte = cmd_num;
        6'd4:    rpl_byte = rpl_value_ff[31:24];
        6'd5:    rpl_byte = rpl_value_ff[23:16];
        6'd6:    rpl_byte = rpl_value_ff[15:8];
        6'd7:    rpl_byte = rpl_value_ff[7:0];
        default: rpl_byte = tx_sum_ff;
      endcase
    end
  end

  // transmitter: reply bytes, or echo of received characters
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      tx_valid    <= 1'b0;
      tx_data     <= 8'h0;
      tx_busy     <= 1'b0;
      tx_idx_ff   <= 6'h3F;
      tx_sum_ff   <= 8'h0;
      echo_now_ff <= 1'b0;
      echo_chr_ff <= 8'h0;
    end else begin
      if (text_mode && rx_valid && state_ff != MCP_REPLY && state_ff != MCP_EXEC
          && startup_cfg[5:4] == 2'b00 && (addr_ok_ff || len_ff == 6'h0)
          && (len_ff != 6'h0 || rx_data == CHR_A_LESS1 + module_addr)) begin
        echo_now_ff <= 1'b1;
        echo_chr_ff <= rx_data;
      end
      if (tx_valid && tx_ready) begin
        tx_valid <= 1'b0;
        if (tx_idx_ff != 6'h3F) begin
          tx_sum_ff <= tx_sum_ff + tx_data;
          tx_idx_ff <= tx_idx_ff + 6'h1;
          if (tx_idx_ff == rpl_len - 6'h1) begin
            tx_idx_ff <= 6'h3F;
            tx_busy   <= 1'b0;
          end
        end else begin
          tx_busy <= 1'b0;
        end
      end else if (!tx_valid && state_ff == MCP_REPLY
                   && (!text_mode || fmt_done || rpl_status_ff == ST_BAD_CMD)) begin
        if (tx_idx_ff == 6'h3F) begin
          tx_idx_ff <= 6'h0;
          tx_sum_ff <= 8'h0;
        end else begin
          tx_valid <= 1'b1;
          tx_busy  <= 1'b1;
          tx_data  <= rpl_byte;
        end
      end else if (!tx_valid && echo_now_ff && state_ff != MCP_REPLY) begin
        echo_now_ff <= 1'b0;
        tx_valid    <= 1'b1;
        tx_busy     <= 1'b1;
        tx_data     <= echo_chr_ff;
      end
    end
  end
  // whole-line echo (bit 4 alone) is not implemented: with bit 4 set no character
  // is echoed, and the host only sees the reply
endmodule // mcp_frame_parser

/* File: src/mcp_pkg.sv */
// package for the motion command frame parser: frame layout, status codes,
// command numbers, text characters and echo configuration bits.
// assumes a byte-wide receive stream and a byte-wide transmit stream.
package mcp_pkg;
  localparam int          SER_CMD_LEN    = 9;
  localparam int          CAN_CMD_LEN    = 7;
  localparam int          SER_RPL_LEN    = 9;
  localparam int          CAN_RPL_LEN    = 6;
  localparam int          TXT_LINE_MAX   = 32;
  localparam logic [7:0]  ST_OK          = 8'h64;
  localparam logic [7:0]  ST_STORED      = 8'h65;
  localparam logic [7:0]  ST_BAD_SUM     = 8'h01;
  localparam logic [7:0]  ST_BAD_CMD     = 8'h02;
  localparam logic [7:0]  ST_BAD_TYPE    = 8'h03;
  localparam logic [7:0]  ST_BAD_VALUE   = 8'h04;
  localparam logic [7:0]  ST_LOCKED      = 8'h05;
  localparam logic [7:0]  ST_UNAVAIL     = 8'h06;
  localparam logic [7:0]  CMD_ENTER_TEXT = 8'h8B;
  localparam logic [7:0]  CHR_CR         = 8'h0D;
  localparam logic [7:0]  CHR_BS         = 8'h08;
  localparam logic [7:0]  CHR_SPACE      = 8'h20;
  localparam logic [7:0]  CHR_MINUS      = 8'h2D;
  localparam logic [7:0]  CHR_ZERO       = 8'h30;
  localparam logic [7:0]  CHR_A_LESS1    = 8'h40;
  localparam int          CFG_TEXT_BIT   = 0;
  localparam int          CFG_ECHO_LINE  = 4;
  localparam int          CFG_ECHO_OFF   = 5;
  localparam logic [7:0]  CFG_RESET      = 8'h00;
  // text command classes handed to the executor, except TXT_CLS_BAD
  localparam logic [1:0]  TXT_CLS_DIRECT = 2'h0;
  localparam logic [1:0]  TXT_CLS_RUN    = 2'h1;
  localparam logic [1:0]  TXT_CLS_STOP   = 2'h2;
  localparam logic [1:0]  TXT_CLS_BAD    = 2'h3;
  typedef enum logic [2:0] {
    MCP_IDLE  = 3'b000,
    MCP_RECV  = 3'b001,
    MCP_EXEC  = 3'b011,
    MCP_REPLY = 3'b010,
    MCP_ECHO  = 3'b110
  } mcp_state_e;
endpackage

/* File: tb/mcp_host_model.sv */
// host side of the link: takes reply bytes, promptly or every third cycle
// assumes tx_valid holds until tx_ready is sampled high
`timescale 1ns/1ps
module mcp_host_model (
  input  wire logic       sys_clk,  // module clock
  input  wire logic       reset,    // sync reset
  input  wire logic       slow,     // stall the transmitter
  input  wire logic       tx_valid, // byte offered
  input  wire logic [7:0] tx_data,  // byte
  output logic            tx_ready  // byte taken
);
  logic [7:0] got[$];
  logic [1:0] ph_ff;
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ph_ff    <= 2'h0;
      tx_ready <= 1'b0;
    end else begin
      ph_ff    <= (ph_ff == 2'h2) ? 2'h0 : ph_ff + 2'h1;
      tx_ready <= !slow || (ph_ff == 2'h1);
    end
  end
  always @(posedge sys_clk) if (tx_valid === 1'b1 && tx_ready) got.push_back(tx_data);
endmodule // mcp_host_model

/* File: tb/mcp_props.sv */
// port checker for the command frame parser
// assumes a bind from the testbench top onto mcp_frame_parser
`timescale 1ns/1ps
module mcp_checker (
  input wire logic       sys_clk,   // module clock
  input wire logic       reset,     // sync reset
  input wire logic       can_link,  // can framing
  input wire logic [7:0] host_addr, // reply address
  input wire logic       cmd_valid, // command pulse
  input wire logic       rx_valid,  // rx byte valid
  input wire logic       txt_valid, // text pulse
  input wire logic       exec_done, // executor answer
  input wire logic       tx_valid,  // tx byte valid
  input wire logic [7:0] tx_data,   // tx byte
  input wire logic       tx_ready,  // tx taken
  input wire logic       tx_busy,   // link driven
  input wire logic       text_mode  // text mode
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  tx_hold_a: assert property (
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data)) else $error("tx byte dropped");
  busy_match_a: assert property (
    tx_valid |-> tx_busy) else $error("tx without busy");
  cmd_pulse_a: assert property (
    cmd_valid |=> !cmd_valid) else $error("command pulse too long");
  txt_pulse_a: assert property (
    txt_valid |=> !txt_valid) else $error("text pulse too long");
  cmd_after_rx_a: assert property (
    cmd_valid |-> $past(rx_valid) || $past(rx_valid, 2)) else $error("command without bytes");
  reply_start_a: assert property (
    exec_done |-> ##[1:16] tx_valid) else $error("no reply after answer");
  ser_addr_a: assert property (
    exec_done && !can_link && !text_mode |-> ##[1:4] (tx_valid && tx_data == host_addr))
    else $error("reply does not open with host address");
  reset_quiet_a: assert property (disable iff (1'b0)
    reset |=> !tx_valid && !cmd_valid && !txt_valid && !text_mode) else $error("active after reset");
endmodule // mcp_checker

/* File: tb/tb.sv */
// top testbench: drives frames and text lines, acts as executor
// assumes the host model collects every transmitted byte
`timescale 1ns/1ps
module tb;
  import mcp_pkg::*;
  logic        sys_clk = 0, reset = 1, can_link = 0, rx_valid = 0, exec_done = 0, slow = 0;
  logic [7:0]  module_addr = 8'h01, host_addr = 8'h02, startup_cfg = 8'h20;
  logic [7:0]  rx_data = 8'h00, exec_status = 8'h00, cmd_num, cmd_type, cmd_bank, tx_data;
  logic [31:0] exec_value = 32'h0, cmd_value;
  logic [1:0]  txt_class;
  logic        cmd_valid, txt_valid, tx_valid, tx_ready, tx_busy, text_mode;
  int          fail_count = 0, checked = 0, cyc = 0, cmd_seen = 0, txt_seen = 0;
  initial forever #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cmd_valid === 1'b1) cmd_seen <= cmd_seen + 1;
    if (txt_valid === 1'b1) txt_seen <= txt_seen + 1;
    if (cyc == 30000) begin
      fail_count++;
      end_of_test();
    end
  end
  mcp_frame_parser dut_u (.sys_clk(sys_clk), .reset(reset), .can_link(can_link),
    .module_addr(module_addr), .host_addr(host_addr), .startup_cfg(startup_cfg),
    .rx_valid(rx_valid), .rx_data(rx_data), .cmd_valid(cmd_valid), .cmd_num(cmd_num),
    .cmd_type(cmd_type), .cmd_bank(cmd_bank), .cmd_value(cmd_value), .txt_valid(txt_valid),
    .txt_class(txt_class), .exec_done(exec_done), .exec_status(exec_status),
    .exec_value(exec_value), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
    .tx_busy(tx_busy), .text_mode(text_mode));
  mcp_host_model host_u (.sys_clk(sys_clk), .reset(reset), .slow(slow),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));
  task end_of_test;
    $display("checked %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task cmp8(input string n, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task cmp32(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task clk(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task do_reset(input logic [7:0] cfg);
    @(posedge sys_clk);
    reset <= 1'b1;
    startup_cfg <= cfg;
    clk(4);
    reset <= 1'b0;
    clk(6);
  endtask
  task send_q(input logic [7:0] q[$]);
    foreach (q[i]) begin
      @(posedge sys_clk);
      rx_valid <= 1'b1;
      rx_data  <= q[i];
    end
    @(posedge sys_clk);
    rx_valid <= 1'b0;
  endtask
  task exec(input logic [7:0] st, input logic [31:0] v);
    @(posedge sys_clk);
    exec_done   <= 1'b1;
    exec_status <= st;
    exec_value  <= v;
    @(posedge sys_clk);
    exec_done <= 1'b0;
  endtask
  task wait_cnt(input bit txt, input int base, output bit ok);
    ok = 0;
    for (int i = 0; i < 40 && !ok; i++) begin
      @(posedge sys_clk);
      #1;
      ok = ((txt ? txt_seen : cmd_seen) > base);
    end
  endtask
  // the next command waits for the whole reply
  task wait_tx(input int n, input bit cr);
    for (int i = 0; i < 600; i++) begin
      if (host_u.got.size() >= n && (!cr || host_u.got[$] === CHR_CR)) break;
      @(posedge sys_clk);
    end
    clk(8);
  endtask
  // mode 0 executed, 1 corrupted checksum, 2 enter text
  task ser(input logic [7:0] num, input logic [7:0] st, input int mode);
    logic [7:0] f[$];
    logic [7:0] e[$];
    logic [7:0] s;
    bit ok;
    int b;
    f = '{module_addr, num, 8'h04, 8'h00, 8'h12, 8'h34, 8'h56, 8'h78};
    s = 8'h00;
    foreach (f[i]) s += f[i];
    f.push_back(mode == 1 ? s + 8'h01 : s);
    host_u.got.delete();
    b = cmd_seen;
    send_q(f);
    wait_cnt(0, b, ok);
    cmp8("cmd seen", {7'h0, mode == 0}, {7'h0, ok});
    if (ok) begin
      cmp8("cmd num", num, cmd_num);
      cmp8("cmd type", 8'h04, cmd_type);
      cmp8("cmd bank", 8'h00, cmd_bank);
      cmp32("cmd value", 32'h12345678, cmd_value);
      exec(st, 32'hA1B2C3D4);
    end
    e = '{host_addr, module_addr, mode == 1 ? ST_BAD_SUM : (mode == 2 ? ST_OK : st),
          num, 8'hA1, 8'hB2, 8'hC3, 8'hD4};
    wait_tx(9, 0);
    cmp8("reply len", 8'h09, 8'(host_u.got.size()));
    s = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (i < 3 || mode == 0) cmp8("reply byte", e[i], host_u.got[i]);
      s += host_u.got[i];
    end
    cmp8("reply sum", s, host_u.got[8]);
    $display("serial test done cmd %h", num);
  endtask
  task can_cmd;
    logic [7:0] f[$];
    bit ok;
    int b;
    can_link <= 1'b1;
    clk(2);
    host_u.got.delete();
    b = cmd_seen;
    f = '{8'h06, 8'h01, 8'h00, 8'h87, 8'h65, 8'h43, 8'h21};
    send_q(f);
    wait_cnt(0, b, ok);
    cmp32("can value", 32'h87654321, cmd_value);
    exec(ST_OK, 32'h0000FF01);
    wait_tx(6, 0);
    cmp8("can len", 8'h06, 8'(host_u.got.size()));
    cmp8("can status", ST_OK, host_u.got[0]);
    cmp8("can cmd", 8'h06, host_u.got[1]);
    for (int i = 0; i < 4; i++) cmp8("can val", 8'(32'h0000FF01 >> (24 - 8 * i)), host_u.got[i + 2]);
    can_link <= 1'b0;
    clk(2);
    $display("can test done");
  endtask
  task other_addr;
    logic [7:0] f[$];
    int b;
    f = '{8'h03, 8'h05, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h09};
    host_u.got.delete();
    b = cmd_seen;
    send_q(f);
    clk(40);
    cmp8("stray reply", 8'h00, 8'(host_u.got.size()));
    cmp8("stray cmd", 8'h00, 8'(cmd_seen - b));
    $display("address filter test done");
  endtask
  task txt_lines;
    string ln[5];
    logic [1:0] cls[3];
    logic [7:0] f[$];
    int b;
    bit ok;
    ln = '{"A SIO 1", "ARUN", "ASTOP", "AXYZ", {"AB", "IN"}};
    cls = '{TXT_CLS_DIRECT, TXT_CLS_RUN, TXT_CLS_STOP};
    for (int k = 0; k < 5; k++) begin
      f.delete();
      for (int i = 0; i < ln[k].len(); i++) f.push_back(ln[k][i]);
      f.push_back(CHR_CR);
      host_u.got.delete();
      b = txt_seen;
      send_q(f);
      wait_cnt(1, b, ok);
      cmp8("txt seen", {7'h0, k < 3}, {7'h0, ok});
      if (ok) begin
        cmp8("txt class", {6'h0, cls[k]}, {6'h0, txt_class});
        exec(ST_OK, 32'hFFFFFFFB);
      end
      if (k < 4) begin
        wait_tx(1, 1);
        cmp8("txt host", CHR_A_LESS1 + host_addr, host_u.got[0]);
        cmp8("txt module", CHR_A_LESS1 + module_addr, host_u.got[1]);
        cmp8("txt end", CHR_CR, host_u.got[$]);
        cmp8("txt status hi", (k == 3) ? "0" : "1", host_u.got[3]);
        cmp8("txt status lo", (k == 3) ? "2" : "0", host_u.got[5]);
        if (k < 3) cmp8("txt value", "5", host_u.got[8]);
      end else begin
        clk(30);
        cmp8("bin quiet", 8'h00, 8'(host_u.got.size()));
        cmp8("bin mode", 8'h00, {7'h0, text_mode});
      end
    end
    $display("text test done");
  endtask
  initial begin
    logic [7:0] q[$];
    clk(4);
    reset <= 1'b0;
    clk(6);
    for (int k = 0; k < 7; k++) begin
      slow <= k[0];
      ser(8'h01 + 8'(k), k == 0 ? ST_OK : (k == 1 ? ST_STORED : 8'(k)), 0);
    end
    ser(8'h05, ST_OK, 1);
    other_addr();
    can_cmd();
    ser(CMD_ENTER_TEXT, ST_OK, 2);
    cmp8("text entered", 8'h01, {7'h0, text_mode});
    txt_lines();
    ser(CMD_ENTER_TEXT, ST_OK, 2);
    do_reset(8'h20);
    cmp8("power cycle mode", 8'h00, {7'h0, text_mode});
    do_reset(8'h21);
    cmp8("startup mode", 8'h01, {7'h0, text_mode});
    q = '{8'h41, 8'h42, 8'h49, 8'h4E, CHR_CR};
    send_q(q);
    clk(10);
    cmp8("startup leave", 8'h00, {7'h0, text_mode});
    $display("mode test done");
    end_of_test();
  end
endmodule // tb
bind mcp_frame_parser mcp_checker chk_u (.sys_clk(sys_clk), .reset(reset), .can_link(can_link),
  .host_addr(host_addr), .cmd_valid(cmd_valid), .rx_valid(rx_valid), .txt_valid(txt_valid),
  .exec_done(exec_done), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
  .tx_busy(tx_busy), .text_mode(text_mode));
